//--- logic/arr_result_regs.sv
// Purpose: Result word and high-byte alias of the 10-bit successive approximation converter
// Assumes: Bus strobes, conversion end and config-write strobe come from logic on clk_sys_i
// Notes: Reads answer one cycle after the strobe; writes to the result addresses do nothing
`timescale 1ns/100ps
`default_nettype none
module arr_result_regs
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// Register bus
	input wire logic [arr_pkg::ADDR_W-1:0] sfr_addr_i,
	input wire logic sfr_rd_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_word_i,
	input wire logic [arr_pkg::DATA_W-1:0] sfr_wdata_i,
	output logic [arr_pkg::DATA_W-1:0] sfr_rdata_o,
	output logic sfr_ack_o,
	// Converter core
	input wire logic conv_end_i,
	input wire logic [arr_pkg::RES_W-1:0] sar_value_i,
	input wire logic cfg_write_i,
	// Status
	output logic result_stale_o
);
	import arr_pkg::*;

	logic [RES_W-1:0] result_r;
	logic [RES_W-1:0] result_nxt;
	logic stale_r;
	logic stale_nxt;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic ack_r;
	logic ack_nxt;
	logic hit_word;
	logic hit_high;
	logic hit_low;
	logic [DATA_W-1:0] word_view;

	// Result store; bus writes never reach it
	always_comb
	begin
		result_nxt = result_r;
		stale_nxt = stale_r;
		if (conv_end_i)
		begin
			result_nxt = sar_value_i;
			stale_nxt = 1'b0;
		end
		// A config write in the same cycle still marks the result suspect
		if (cfg_write_i)
			stale_nxt = 1'b1;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!resetn_i)
		begin
			result_r <= RESET_RESULT;
			stale_r <= 1'b0;
		end
		else
		begin
			result_r <= result_nxt;
			stale_r <= stale_nxt;
		end
	end

	// Read decode
	assign word_view = {result_r, ZERO_FILL};
	assign hit_word = sfr_rd_i && sfr_word_i && (sfr_addr_i == OFF_RESULT_WORD);
	assign hit_high = sfr_rd_i && !sfr_word_i && (sfr_addr_i == OFF_RESULT_HIGH);
	assign hit_low = sfr_rd_i && !sfr_word_i && (sfr_addr_i == OFF_RESULT_WORD);

	always_comb
	begin
		rdata_nxt = RESET_WORD;
		ack_nxt = 1'b0;
		if (hit_word)
		begin
			rdata_nxt = word_view;
			ack_nxt = 1'b1;
		end
		else if (hit_high)
		begin
			rdata_nxt = {ZERO_BYTE, word_view[DATA_W-1:BYTE_W]};
			ack_nxt = 1'b1;
		end
		else if (hit_low)
		begin
			rdata_nxt = {ZERO_BYTE, word_view[BYTE_W-1:0]};
			ack_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!resetn_i)
		begin
			rdata_r <= RESET_WORD;
			ack_r <= 1'b0;
		end
		else
		begin
			rdata_r <= rdata_nxt;
			ack_r <= ack_nxt;
		end
	end

	assign sfr_rdata_o = rdata_r;
	assign sfr_ack_o = ack_r;
	assign result_stale_o = stale_r;

	// Checks
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!resetn_i);

	sequence s_word_read;
		sfr_rd_i && sfr_word_i && sfr_addr_i == OFF_RESULT_WORD;
	endsequence

	sequence s_high_read;
		sfr_rd_i && !sfr_word_i && sfr_addr_i == OFF_RESULT_HIGH;
	endsequence

	a_result_load: assert property (conv_end_i |=> result_r == $past(sar_value_i))
		else $error("result not loaded at conversion end");
	a_writes_ignored: assert property (sfr_wr_i && !conv_end_i |=> result_r == $past(result_r))
		else $error("bus write changed the result");
	a_word_value: assert property (s_word_read ##0 !conv_end_i |=> sfr_ack_o
		&& sfr_rdata_o == {result_r, ZERO_FILL})
		else $error("word read returned wrong value");
	a_low_zero: assert property (s_word_read |=> sfr_rdata_o[ZERO_W-1:0] == ZERO_FILL)
		else $error("low six bits not zero");
	a_high_alias: assert property (s_high_read |=> sfr_ack_o
		&& sfr_rdata_o == {ZERO_BYTE, $past(result_r[RES_W-1:RES_LOW_W])})
		else $error("high byte read wrong");
	a_low_byte: assert property (sfr_rd_i && !sfr_word_i && sfr_addr_i == OFF_RESULT_WORD
		|=> sfr_rdata_o == {ZERO_BYTE, $past(result_r[RES_LOW_W-1:0]), ZERO_FILL})
		else $error("low byte layout wrong");
	a_unmapped_read: assert property (sfr_rd_i && !(hit_word || hit_high || hit_low)
		|=> !sfr_ack_o && sfr_rdata_o == RESET_WORD)
		else $error("unmapped read answered");
	a_stale_mark: assert property (cfg_write_i |=> result_stale_o)
		else $error("config write not flagged");
	a_reset_clear: assert property (disable iff (1'b0) !resetn_i |=> result_r == RESET_RESULT
		&& sfr_rdata_o == RESET_WORD && !sfr_ack_o)
		else $error("reset did not clear results");

	// Bus handshake and flag checks
	sequence s_low_read;
		sfr_rd_i && !sfr_word_i && sfr_addr_i == OFF_RESULT_WORD;
	endsequence

	sequence s_odd_word;
		sfr_rd_i && sfr_word_i && sfr_addr_i == OFF_RESULT_HIGH;
	endsequence

	sequence s_write_only;
		sfr_wr_i && !sfr_rd_i;
	endsequence

	sequence s_conv_only;
		conv_end_i && !cfg_write_i;
	endsequence

	// An answer only ever follows a read strobe
	property p_ack_source;
		sfr_ack_o |-> $past(sfr_rd_i);
	endproperty
	a_ack_source: assert property (p_ack_source)
		else $error("ack without read");

	// No strobe, no answer
	property p_ack_idle;
		!sfr_rd_i |=> !sfr_ack_o;
	endproperty
	a_ack_idle: assert property (p_ack_idle)
		else $error("ack while idle");

	// Read data falls back to zero once the answer is gone
	property p_rdata_idle;
		!sfr_rd_i |=> sfr_rdata_o == RESET_WORD;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not cleared");

	// Data is zero whenever no answer stands
	property p_rdata_noack;
		!sfr_ack_o |-> sfr_rdata_o == RESET_WORD;
	endproperty
	a_rdata_noack: assert property (p_rdata_noack)
		else $error("data without ack");

	// Writes get no answer
	property p_write_silent;
		s_write_only |=> !sfr_ack_o;
	endproperty
	a_write_silent: assert property (p_write_silent)
		else $error("write answered");

	// A word access at the odd address is not mapped
	property p_odd_word;
		s_odd_word |=> !sfr_ack_o && sfr_rdata_o == RESET_WORD;
	endproperty
	a_odd_word: assert property (p_odd_word)
		else $error("odd word access answered");

	// A conversion end alone clears the suspect mark
	property p_stale_clear;
		s_conv_only |=> !result_stale_o;
	endproperty
	a_stale_clear: assert property (p_stale_clear)
		else $error("stale mark not cleared");

	// The suspect mark holds without events
	property p_stale_hold;
		!conv_end_i && !cfg_write_i |=> result_stale_o == $past(result_stale_o);
	endproperty
	a_stale_hold: assert property (p_stale_hold)
		else $error("stale mark changed");

	// The result changes only at a conversion end
	property p_result_hold;
		!conv_end_i |=> result_r == $past(result_r);
	endproperty
	a_result_hold: assert property (p_result_hold)
		else $error("result changed without conversion");

	// High byte read leaves the upper data byte zero
	property p_high_upper;
		s_high_read |=> sfr_rdata_o[DATA_W-1:BYTE_W] == ZERO_BYTE;
	endproperty
	a_high_upper: assert property (p_high_upper)
		else $error("high byte read upper not zero");

	// Low byte read leaves the upper data byte zero
	property p_low_upper;
		s_low_read |=> sfr_rdata_o[DATA_W-1:BYTE_W] == ZERO_BYTE;
	endproperty
	a_low_upper: assert property (p_low_upper)
		else $error("low byte read upper not zero");

	// A read shows the value stored before a same-cycle load
	property p_read_before_load;
		s_word_read ##0 conv_end_i |=> sfr_rdata_o == {$past(result_r), ZERO_FILL};
	endproperty
	a_read_before_load: assert property (p_read_before_load)
		else $error("read saw new value too early");

	// Back-to-back reads are each answered
	property p_read_pair;
		s_word_read ##1 s_high_read |-> sfr_ack_o ##1 sfr_ack_o;
	endproperty
	a_read_pair: assert property (p_read_pair)
		else $error("back-to-back read missed");

	// Reset clears the suspect mark
	property p_reset_stale;
		disable iff (1'b0) !resetn_i |=> !result_stale_o;
	endproperty
	a_reset_stale: assert property (p_reset_stale)
		else $error("reset left stale mark");

	// Word upper byte equals the high byte view
	property p_word_alias;
		s_word_read ##0 !conv_end_i |=> sfr_rdata_o[DATA_W-1:BYTE_W]
			== result_r[RES_W-1:RES_LOW_W];
	endproperty
	a_word_alias: assert property (p_word_alias)
		else $error("word upper byte mismatch");

	// Config write with a conversion end still loads but marks suspect
	property p_load_after_cfg;
		cfg_write_i && conv_end_i |=> result_stale_o && result_r == $past(sar_value_i);
	endproperty
	a_load_after_cfg: assert property (p_load_after_cfg)
		else $error("load with config write wrong");

	// A high byte read is answered
	property p_high_ack;
		s_high_read |=> sfr_ack_o;
	endproperty
	a_high_ack: assert property (p_high_ack)
		else $error("high byte read not answered");

	// A low byte read is answered
	property p_low_ack;
		s_low_read |=> sfr_ack_o;
	endproperty
	a_low_ack: assert property (p_low_ack)
		else $error("low byte read not answered");
endmodule
`default_nettype wire

//--- logic/arr_pkg.sv
// Purpose: Shared constants for the converter result register block
// Assumes: 20-bit byte address space on the peripheral register bus
// Notes: Offsets and reset values are used by the design only through these names
`default_nettype none
package arr_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int RES_W = 10;
	localparam int RES_LOW_W = 2;
	localparam int ZERO_W = 6;
	localparam logic [ADDR_W-1:0] OFF_RESULT_WORD = 20'hFFF1E;
	localparam logic [ADDR_W-1:0] OFF_RESULT_HIGH = 20'hFFF1F;
	localparam logic [RES_W-1:0] RESET_RESULT = 10'h000;
	localparam logic [DATA_W-1:0] RESET_WORD = 16'h0000;
	localparam logic [BYTE_W-1:0] RESET_HIGH = 8'h00;
	localparam logic [ZERO_W-1:0] ZERO_FILL = 6'h00;
	localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;
endpackage
`default_nettype wire

//--- tb/arr_result_regs_tb.sv
// Purpose: Random and corner reads of the converter result registers
// Assumes: One-cycle read answer with ack, writes ignored
// Notes: The stale flag stands in for undefined results
`timescale 1ns/100ps
`default_nettype none
module arr_result_regs_tb;
import arr_pkg::*;
logic clk_sys_i = 0, resetn_i = 0, rd = 0, wr = 0, wd = 0, ce = 0, cw = 0, ack, stale;
logic [ADDR_W-1:0] ad = 20'h00000;
logic [DATA_W-1:0] wdat = 16'h0000, rdat;
logic [RES_W-1:0] sar = 10'h000, v;
logic [31:0] seed = 32'h000063CF;
int err_count = 0, checks_done = 0, cyc = 0;
arr_result_regs i_arr_result_regs (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .sfr_addr_i(ad),
	.sfr_rd_i(rd), .sfr_wr_i(wr), .sfr_word_i(wd), .sfr_wdata_i(wdat), .sfr_rdata_o(rdat),
	.sfr_ack_o(ack), .conv_end_i(ce), .sar_value_i(sar), .cfg_write_i(cw), .result_stale_o(stale));
initial
begin
	forever #4 clk_sys_i = ~clk_sys_i;
end
function automatic logic [31:0] xs();
	seed = seed ^ (seed << 13);
	seed = seed ^ (seed >> 17);
	seed = seed ^ (seed << 5);
	return seed;
endfunction
// Expected read data: 0 word, 1 high byte, 2 low byte
function automatic logic [15:0] expv(input logic [9:0] r, input int k);
	return k == 0 ? {r, 6'h00} : (k == 1 ? {8'h00, r[9:2]} : {8'h00, r[1:0], 6'h00});
endfunction
task automatic give_verdict();
	$display("checks=%0d errors=%0d", checks_done, err_count);
	if (err_count == 0 && checks_done > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
endtask
task automatic chk(input logic [15:0] g, input logic [15:0] e);
	checks_done++;
	if (g !== e)
	begin
		$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		err_count++;
	end
endtask
task automatic rd_chk(input logic [19:0] a, input logic w, input logic [15:0] e, input logic ae);
	@(posedge clk_sys_i);
	rd <= 1'h1;
	ad <= a;
	wd <= w;
	@(posedge clk_sys_i);
	rd <= 1'h0;
	#1;
	chk({15'h0000, ack}, {15'h0000, ae});
	chk(rdat, e);
endtask
task automatic conv(input logic [9:0] x, input logic c);
	@(posedge clk_sys_i);
	ce <= 1'h1;
	sar <= x;
	cw <= c;
	@(posedge clk_sys_i);
	ce <= 1'h0;
	cw <= 1'h0;
	#1;
	chk({15'h0000, stale}, {15'h0000, c});
endtask
always @(posedge clk_sys_i)
begin
	cyc++;
	if (cyc == 5000)
	begin
		err_count++;
		give_verdict();
	end
end
initial
begin
	repeat (20) @(posedge clk_sys_i);
	resetn_i <= 1'h1;
	rd_chk(OFF_RESULT_WORD, 1'h1, RESET_WORD, 1'h1);
	rd_chk(OFF_RESULT_HIGH, 1'h0, {8'h00, RESET_HIGH}, 1'h1);
	for (int i = 0; i < 24; i++)
	begin
		v = i == 0 ? 10'h3FF : (i == 1 ? 10'h001 : xs() & 32'h000003FF);
		conv(v, 1'h0);
		rd_chk(OFF_RESULT_WORD, 1'h1, expv(v, 0), 1'h1);
		rd_chk(OFF_RESULT_HIGH, 1'h0, expv(v, 1), 1'h1);
		rd_chk(OFF_RESULT_WORD, 1'h0, expv(v, 2), 1'h1);
		@(posedge clk_sys_i);
		wr <= 1'h1;
		wdat <= xs() & 32'h0000FFFF;
		ad <= i[0] ? OFF_RESULT_HIGH : OFF_RESULT_WORD;
		@(posedge clk_sys_i);
		wr <= 1'h0;
		rd_chk(OFF_RESULT_WORD, 1'h1, expv(v, 0), 1'h1);
	end
	conv(10'h155, 1'h1);
	conv(10'h2AA, 1'h0);
	rd_chk(OFF_RESULT_HIGH, 1'h1, 16'h0000, 1'h0);
	rd_chk(20'hFFF20, 1'h0, 16'h0000, 1'h0);
	give_verdict();
end
endmodule
`default_nettype wire
